// ===== design/rpcg_defines.svh
// Offsets, field positions, reset values and masks of the peripheral clock gate block
`ifndef RPCG_DEFINES_SVH
`define RPCG_DEFINES_SVH

// Address map
`define RPCG_BASE_ADDR 32'h400F_E000
`define RPCG_OFF_MODE_CFG 12'h060
`define RPCG_OFF_RUN_ONE 12'h104
`define RPCG_OFF_RUN_TWO 12'h108
`define RPCG_OFF_SLEEP_TWO 12'h118
`define RPCG_OFF_DEEP_TWO 12'h128
`define RPCG_OFF_STATUS 12'h140
`define RPCG_OFF_MASK 12'h144

// Field positions
`define RPCG_POS_PHY 30
`define RPCG_POS_MAC 28
`define RPCG_POS_PORT_LO 0
`define RPCG_POS_PORT_HI 7
`define RPCG_POS_SERIAL_LO 0
`define RPCG_POS_SERIAL_HI 2
`define RPCG_POS_AUTO_GATE 27
`define RPCG_POS_ST_FAULT 0
`define RPCG_POS_ST_UNMAPPED 1

// Writable bits and reset values
`define RPCG_GATE_TWO_WMASK 32'h5000_00FF
`define RPCG_GATE_ONE_WMASK 32'h0000_0007
`define RPCG_GATE_RESET 32'h0000_0000
`define RPCG_MASK_RESET 2'h0

// Bus answers and sizes
`define RPCG_RESP_OKAY 2'h0
`define RPCG_RESP_SLVERR 2'h2
`define RPCG_UNITS 13
`define RPCG_EVENTS 2

`endif

// ===== design/rpcg_pkg.sv
// Types shared by the peripheral clock gate block
`include "rpcg_defines.svh"

package rpcg_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        RPCG_SEL_NONE,
        RPCG_SEL_MODE_CFG,
        RPCG_SEL_RUN_ONE,
        RPCG_SEL_RUN_TWO,
        RPCG_SEL_SLEEP_TWO,
        RPCG_SEL_DEEP_TWO,
        RPCG_SEL_STATUS,
        RPCG_SEL_MASK
    } rpcg_sel_t;

    // Whole state of the top module
    typedef struct packed {
        logic [31:0] run_two;
        logic [31:0] run_one;
        logic [31:0] sleep_two;
        logic [31:0] deep_two;
        logic auto_gate;
        logic [`RPCG_EVENTS-1:0] status;
        logic [`RPCG_EVENTS-1:0] mask;
        logic aw_full;
        rpcg_sel_t aw_sel;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [`RPCG_UNITS-1:0] unit_en;
        logic [`RPCG_UNITS-1:0] unit_fault;
        logic irq;
    } rpcg_state_t;

endpackage

// ===== design/rpcg_clock_gate.sv
// Glitch-free clock gating cell, enable held by a latch while the clock is high
`timescale 1ns/1ps

module rpcg_clock_gate (
    // Clock and enable
    input wire logic clk_in,
    input wire logic enable,
    // Gated clock
    output logic clk_out
);

    logic en_latch;

    // Enable passes only while the clock is low, so no pulse is cut short
    always_latch begin
        if (!clk_in) begin
            en_latch = enable;
        end
    end

    // Gate the clock with the held enable
    assign clk_out = clk_in & en_latch;

endmodule

// ===== design/rpcg_gate_ctrl.sv
// Peripheral clock gating registers with an AXI4-Lite slave and bus fault checking
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rpcg_defines.svh"

// How it works
// [RL1] Bit 30 of the run gating register enables the Ethernet PHY clock.
// [RL2] Bit 28 of the run gating register enables the Ethernet MAC clock.
// [RL3] Bits 7 to 0 enable ports H to A, bit 0 is port A.
// [RL4] Bits 2, 1, 0 of the preceding register enable serial units 2, 1, 0.
// [RL5] Any access to a unit whose gate is zero gets a bus fault.
// [RL6] A set bit delivers the unit clock, a clear bit removes it.
// [RL7] Reset loads zero, so every gated unit starts unclocked.
// [RL8] The run gating register decodes at offset 0x108 from base 0x400FE000.
// [RL9] Reserved bits are read-only zero; software preserves them on updates.
// [RL10] Run register applies when running; sleep registers apply with auto gating. Serial units keep the run_one enables in every mode.
// [RL11] Software enables each needed unit before touching it.
// [RL12] Each gate switches its clock without glitches, using a latch cell.
module rpcg_gate_ctrl #(
    parameter int ADDR_WIDTH = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // AXI4-Lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power mode of the system
    input wire logic sleep_mode,
    input wire logic deep_sleep_mode,
    // Unit accesses and their faults
    input wire logic [`RPCG_UNITS-1:0] unit_access,
    output logic [`RPCG_UNITS-1:0] unit_fault,
    // Unit clock enables and gated clocks
    output logic [`RPCG_UNITS-1:0] unit_clock_enable,
    output logic [`RPCG_UNITS-1:0] unit_clk,
    // Interrupt
    output logic irq
);

    localparam logic [31:0] BASE_ADDR = `RPCG_BASE_ADDR;

    rpcg_pkg::rpcg_state_t q;
    rpcg_pkg::rpcg_state_t d;

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Map a bus address onto a register
    function automatic rpcg_pkg::rpcg_sel_t decode(input logic [ADDR_WIDTH-1:0] addr);
        rpcg_pkg::rpcg_sel_t sel;
        logic [11:0] off;
        sel = rpcg_pkg::RPCG_SEL_NONE;
        off = addr[11:0];
        if (addr[ADDR_WIDTH-1:12] != BASE_ADDR[ADDR_WIDTH-1:12]) begin
            sel = rpcg_pkg::RPCG_SEL_NONE;
        end else if (off == `RPCG_OFF_RUN_TWO) begin
            sel = rpcg_pkg::RPCG_SEL_RUN_TWO; // RL8
        end else if (off == `RPCG_OFF_RUN_ONE) begin
            sel = rpcg_pkg::RPCG_SEL_RUN_ONE;
        end else if (off == `RPCG_OFF_SLEEP_TWO) begin
            sel = rpcg_pkg::RPCG_SEL_SLEEP_TWO;
        end else if (off == `RPCG_OFF_DEEP_TWO) begin
            sel = rpcg_pkg::RPCG_SEL_DEEP_TWO;
        end else if (off == `RPCG_OFF_MODE_CFG) begin
            sel = rpcg_pkg::RPCG_SEL_MODE_CFG;
        end else if (off == `RPCG_OFF_STATUS) begin
            sel = rpcg_pkg::RPCG_SEL_STATUS;
        end else if (off == `RPCG_OFF_MASK) begin
            sel = rpcg_pkg::RPCG_SEL_MASK;
        end
        return sel;
    endfunction

    // Merge byte lanes and keep reserved bits at zero
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res & wmask; // RL9
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [31:0] gate_two;
        logic [31:0] mode_word;
        logic [`RPCG_EVENTS-1:0] events;
        gate_two = 32'h0000_0000;
        mode_word = 32'h0000_0000;
        events = '0;
        d = q;

        // Write address channel
        if (s_axi_awvalid && q.awready) begin
            d.aw_full = 1'b1;
            d.aw_sel = decode(s_axi_awaddr);
        end

        // Write data channel
        if (s_axi_wvalid && q.wready) begin
            d.w_full = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end

        // Write response retired
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        // Perform the write once address and data are both held
        if (d.aw_full && d.w_full && !d.bvalid) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RPCG_RESP_OKAY;
            if (d.aw_sel == rpcg_pkg::RPCG_SEL_RUN_TWO) begin
                d.run_two = merge(q.run_two, d.wdata, d.wstrb, `RPCG_GATE_TWO_WMASK); // RL9
            end else if (d.aw_sel == rpcg_pkg::RPCG_SEL_RUN_ONE) begin
                d.run_one = merge(q.run_one, d.wdata, d.wstrb, `RPCG_GATE_ONE_WMASK);
            end else if (d.aw_sel == rpcg_pkg::RPCG_SEL_SLEEP_TWO) begin
                d.sleep_two = merge(q.sleep_two, d.wdata, d.wstrb, `RPCG_GATE_TWO_WMASK);
            end else if (d.aw_sel == rpcg_pkg::RPCG_SEL_DEEP_TWO) begin
                d.deep_two = merge(q.deep_two, d.wdata, d.wstrb, `RPCG_GATE_TWO_WMASK);
            end else if (d.aw_sel == rpcg_pkg::RPCG_SEL_MODE_CFG) begin
                mode_word = merge({4'h0, q.auto_gate, 27'h0}, d.wdata, d.wstrb,
                                  32'h0800_0000);
                d.auto_gate = mode_word[`RPCG_POS_AUTO_GATE];
            end else if (d.aw_sel == rpcg_pkg::RPCG_SEL_MASK) begin
                d.mask = d.wstrb[0] ? d.wdata[`RPCG_EVENTS-1:0] : q.mask;
            end else if (d.aw_sel == rpcg_pkg::RPCG_SEL_STATUS) begin
                d.bresp = `RPCG_RESP_OKAY;
            end else begin
                d.bresp = `RPCG_RESP_SLVERR;
                events[`RPCG_POS_ST_UNMAPPED] = 1'b1;
            end
        end

        // Read data retired
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Read address taken and answered on the next edge
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = `RPCG_RESP_OKAY;
            d.rdata = 32'h0000_0000;
            case (decode(s_axi_araddr))
                rpcg_pkg::RPCG_SEL_RUN_TWO: d.rdata = q.run_two; // RL9
                rpcg_pkg::RPCG_SEL_RUN_ONE: d.rdata = q.run_one;
                rpcg_pkg::RPCG_SEL_SLEEP_TWO: d.rdata = q.sleep_two;
                rpcg_pkg::RPCG_SEL_DEEP_TWO: d.rdata = q.deep_two;
                rpcg_pkg::RPCG_SEL_MODE_CFG: d.rdata = {4'h0, q.auto_gate, 27'h0};
                rpcg_pkg::RPCG_SEL_MASK: d.rdata = {30'h0, q.mask};
                rpcg_pkg::RPCG_SEL_STATUS: begin
                    d.rdata = {30'h0, q.status};
                    d.status = '0;
                end
                default: begin
                    d.rresp = `RPCG_RESP_SLVERR;
                    events[`RPCG_POS_ST_UNMAPPED] = 1'b1;
                end
            endcase
        end

        // Choose the gating word for the current power mode
        if (q.auto_gate && deep_sleep_mode) begin
            gate_two = q.deep_two; // RL10
        end else if (q.auto_gate && sleep_mode) begin
            gate_two = q.sleep_two; // RL10
        end else begin
            gate_two = q.run_two; // RL10
        end

        // Unit enables: ports, MAC, PHY, then serial units
        d.unit_en[7:0] = gate_two[`RPCG_POS_PORT_HI:`RPCG_POS_PORT_LO]; // RL3
        d.unit_en[8] = gate_two[`RPCG_POS_MAC]; // RL2
        d.unit_en[9] = gate_two[`RPCG_POS_PHY]; // RL1
        d.unit_en[12:10] = q.run_one[`RPCG_POS_SERIAL_HI:`RPCG_POS_SERIAL_LO]; // RL4

        // Accesses to unclocked units fault
        d.unit_fault = unit_access & ~q.unit_en; // RL5
        events[`RPCG_POS_ST_FAULT] = |d.unit_fault;

        // Sticky events, setting wins over the read clear
        d.status = d.status | events;
        d.irq = |(d.status & d.mask);

        // Channel readiness
        d.awready = !d.aw_full && !d.bvalid;
        d.wready = !d.w_full && !d.bvalid;
        d.arready = !d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.run_two <= `RPCG_GATE_RESET; // RL7
            q.run_one <= `RPCG_GATE_RESET; // RL7
            q.sleep_two <= `RPCG_GATE_RESET;
            q.deep_two <= `RPCG_GATE_RESET;
            q.mask <= `RPCG_MASK_RESET;
            q.aw_sel <= rpcg_pkg::RPCG_SEL_NONE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign unit_fault = q.unit_fault;
    assign unit_clock_enable = q.unit_en; // RL6
    assign irq = q.irq;

    // One glitch-free gate per unit
    for (genvar g = 0; g < `RPCG_UNITS; g++) begin : gen_gate
        rpcg_clock_gate u_gate (
            .clk_in(mclk),
            .enable(q.unit_en[g]), // RL12
            .clk_out(unit_clk[g])
        );
    end

endmodule

// ===== testbench/rpcg_gate_ctrl_sva.sv
// Bus handshake, fault and interrupt checks for the gate controller
`timescale 1ns/1ps

module rpcg_gate_ctrl_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Units and interrupt
    input wire logic [12:0] unit_access,
    input wire logic [12:0] unit_fault,
    input wire logic [12:0] unit_clock_enable,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    logic [1:0] done_q;

    // History of accepted bus requests, a status read or mask write lowers the interrupt
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) done_q <= 2'h0;
        else done_q <= {done_q[0], (s_axi_arvalid & s_axi_arready)
            | (s_axi_awvalid & s_axi_awready) | (s_axi_wvalid & s_axi_wready)};
    end

    ////////////////////////////////////////////////////////////////////////////////
    chk_fault_gated: assert property (unit_fault == $past(unit_access & ~unit_clock_enable))
        else $error("unit fault differs from gated access");
    chk_b_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while answer pending");
    chk_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready while answer pending");
    chk_irq_clear: assert property ($fell(irq) |-> |done_q)
        else $error("interrupt fell without bus access");
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the peripheral clock gate controller
`timescale 1ns/1ps

bind rpcg_gate_ctrl rpcg_gate_ctrl_sva chk_u (.mclk, .arst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .unit_access, .unit_fault,
    .unit_clock_enable, .irq);

module tb_top;
    localparam logic [31:0] BASE = 32'h400F_E000;
    logic mclk = 1'h0, arst_n = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
    logic slp = 1'h0, dsl = 1'h0, awr, wrd, bv, arr, rv, irq;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd_q, r1 = 32'h0, r2 = 32'h0, d;
    logic [1:0] br, rr;
    logic [12:0] acc = 13'h0, x, flt, en, uclk;
    logic [3:0] ws = 4'hF;
    int errors = 0, compares = 0, st = 0;

    rpcg_gate_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_q), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .sleep_mode(slp), .deep_sleep_mode(dsl),
        .unit_access(acc), .unit_fault(flt), .unit_clock_enable(en), .unit_clk(uclk), .irq(irq));

    // Clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge mclk);
        awa <= a; wd <= v; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
        fork
            begin do @(negedge mclk); while (!awr); @(posedge mclk); awv <= 1'h0; end
            begin do @(negedge mclk); while (!wrd); @(posedge mclk); wv <= 1'h0; end
        join
        do @(negedge mclk); while (!bv);
        chk("bresp", 32'(er), 32'(br));
        @(posedge mclk);
        bry <= 1'h0;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge mclk);
        ara <= a; arv <= 1'h1; rry <= 1'h1;
        do @(negedge mclk); while (!arr);
        @(posedge mclk);
        arv <= 1'h0;
        do @(negedge mclk); while (!rv);
        chk("rdata", e, rd_q);
        chk("rresp", 32'(er), 32'(rr));
        @(posedge mclk);
        rry <= 1'h0;
    endtask

    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Expected enables: ports A..H, MAC, PHY, serial 0..2
    function automatic logic [12:0] en_x();
        return {r1[2:0], r2[30], r2[28], r2[7:0]};
    endfunction

    // Watchdog
    initial begin
        #(4000 * 50);
        errors++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'h1;
        @(posedge mclk);
        void'($urandom(29));
        rd(BASE + 32'h108, 32'h0, 2'h0);
        chk("enable", 32'h0, 32'(en));
        $display("test reset done");
        // Random gate patterns with random unit accesses
        repeat (8) begin
            d = $urandom();
            wr(BASE + 32'h108, d, 2'h0);
            r2 = d & 32'h5000_00FF;
            d = $urandom();
            wr(BASE + 32'h104, d, 2'h0);
            r1 = d & 32'h7;
            rd(BASE + 32'h108, r2, 2'h0);
            rd(BASE + 32'h104, r1, 2'h0);
            chk("enable", 32'(en_x()), 32'(en));
            #12 chk("uclk", 32'(en_x()), 32'(uclk));
            x = 13'($urandom());
            @(posedge mclk);
            acc <= x;
            @(posedge mclk);
            acc <= 13'h0;
            if ((x & ~en_x()) != 0) st = st | 1;
            @(negedge mclk);
            chk("fault", 32'(x & ~en_x()), 32'(flt));
        end
        // Byte strobes: only the low lane of the run register changes
        ws <= 4'h1;
        wr(BASE + 32'h108, 32'hFFFF_FFA5, 2'h0);
        ws <= 4'hF;
        r2 = (r2 & 32'hFFFF_FF00) | 32'hA5;
        rd(BASE + 32'h108, r2, 2'h0);
        chk("enable", 32'(en_x()), 32'(en));
        $display("test gating done");
        // Unmapped access, masked then unmasked interrupt, status clear
        wr(BASE + 32'h200, 32'h1, 2'h2);
        rd(BASE + 32'h200, 32'h0, 2'h2);
        st = st | 2;
        chk("irq", 32'h0, 32'(irq));
        wr(BASE + 32'h144, 32'h3, 2'h0);
        repeat (2) @(posedge mclk);
        chk("irq", 32'h1, 32'(irq));
        rd(BASE + 32'h140, 32'(st), 2'h0);
        repeat (2) @(posedge mclk);
        chk("irq", 32'h0, 32'(irq));
        $display("test interrupt done");
        // Sleep and deep sleep gating with auto gating on
        wr(BASE + 32'h060, 32'h0800_0000, 2'h0);
        wr(BASE + 32'h118, 32'hFFFF_FFFF, 2'h0);
        d = $urandom();
        wr(BASE + 32'h128, d, 2'h0);
        rd(BASE + 32'h118, 32'h5000_00FF, 2'h0);
        rd(BASE + 32'h128, d & 32'h5000_00FF, 2'h0);
        rd(BASE + 32'h060, 32'h0800_0000, 2'h0);
        slp <= 1'h1;
        repeat (3) @(posedge mclk);
        chk("sleep", 32'({r1[2:0], 10'h3FF}), 32'(en));
        dsl <= 1'h1;
        repeat (3) @(posedge mclk);
        chk("deep", 32'({r1[2:0], d[30], d[28], d[7:0]}), 32'(en));
        slp <= 1'h0;
        dsl <= 1'h0;
        repeat (3) @(posedge mclk);
        chk("run", 32'(en_x()), 32'(en));
        // Sleep without auto gating keeps the run word
        wr(BASE + 32'h060, 32'h0, 2'h0);
        slp <= 1'h1;
        repeat (3) @(posedge mclk);
        chk("manual", 32'(en_x()), 32'(en));
        slp <= 1'h0;
        $display("test modes done");
        test_done();
    end
endmodule
